// ### verilog/rtci_params.svh
// constants of the remote test control block
// assumes 250 MHz aclk; included by the synchroniser and top design files
`ifndef RTCI_PARAMS_SVH
`define RTCI_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTCI_CLK_PERIOD_PS 4000
`define RTCI_MS_PS         1000000000
`define RTCI_MS_CYCLES     (`RTCI_MS_PS / `RTCI_CLK_PERIOD_PS)
`define RTCI_PASS_PULSE_MS 8'd200
`define RTCI_TWO_ACTION_MS 10'd500

// ----------------------------------------------------------------
// program limits
// ----------------------------------------------------------------
`define RTCI_STEPS_MAX     7'd100
`define RTCI_PROGS_MAX     7'd100
`define RTCI_TOTAL_MAX     10'd500
`define RTCI_STEPS_RST     7'd1

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define RTCI_OFF_CTRL      8'h00
`define RTCI_OFF_HOLD      8'h04
`define RTCI_OFF_PROG      8'h08
`define RTCI_OFF_STATUS    8'h0c
`define RTCI_OFF_SELECT    8'h10
`define RTCI_OFF_TOTAL     8'h14
`define RTCI_OFF_BUSIF     8'h18
`define RTCI_SW_START_BIT  5
`define RTCI_SW_STOP_BIT   6
`define RTCI_FOREVER_BIT   16
`define RTCI_PROG_CNT_LSB  8
`define RTCI_RESP_OKAY     2'b00
`define RTCI_RESP_SLVERR   2'b10
`define RTCI_PIN_IDLE      1'b1

`endif

// ### verilog/rtci_pkg.sv
// types of the remote test control block
// state codes set here; other numeric constants are in rtci_params.svh
package rtci_pkg;

  typedef enum logic [2:0] {
    RTCI_ST_IDLE = 3'b000,
    RTCI_ST_RAMP = 3'b001,
    RTCI_ST_MEAS = 3'b010,
    RTCI_ST_PASS = 3'b011,
    RTCI_ST_FAIL = 3'b100,
    RTCI_ST_PROT = 3'b101
  } rtci_state_t;

  typedef struct packed {
    logic contact_start;
    logic two_action;
    logic stop_lockout;
    logic momentary;
    logic pass_hold;
  } rtci_ctrl_t;

  typedef struct packed {
    logic ramp_done;
    logic pass;
    logic upper_fail;
    logic lower_fail;
    logic protect;
    logic contact_current;
  } rtci_judge_t;

  typedef struct packed {
    logic protection;
    logic ready;
    logic lower_fail;
    logic upper_fail;
    logic pass;
    logic measuring;
    logic test_on;
  } rtci_out_t;

endpackage

// ### verilog/rtci_sync.sv
// two-stage synchroniser for a group of connector inputs
// assumes inputs asynchronous to aclk; idles high after reset
`timescale 1ns/1ps
`include "rtci_params.svh"
module rtci_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rtci_sync_t;

  rtci_sync_t r_reg;
  rtci_sync_t r_next;

  always_comb
  begin
    r_next    = r_reg;
    r_next.s1 = din;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_reg <= '{s1: {W{`RTCI_PIN_IDLE}}, s2: {W{`RTCI_PIN_IDLE}}};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign dout = r_reg.s2;
endmodule

// ### verilog/rtci_tick.sv
// divider giving a one-cycle millisecond enable
// assumes aclk; CYCLES is the period in clock cycles
`timescale 1ns/1ps
module rtci_tick #(
  parameter int unsigned CYCLES = 250000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } rtci_tick_t;

  rtci_tick_t r_reg;
  rtci_tick_t r_next;

  always_comb
  begin
    r_next      = r_reg;
    r_next.tick = (r_reg.cnt == 32'h0);
    if (r_reg.cnt == 32'h0)
    begin
      r_next.cnt = 32'(CYCLES - 1);
    end
    else
    begin
      r_next.cnt = r_reg.cnt - 32'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;
endmodule

// ### verilog/rtci_top.sv
// remote connector control, test sequencing and register slave
// assumes connector pins async to aclk, judge inputs on aclk
// Functional notes
// [RULE1] controller drives two BCD digits on eight active-low select lines
// [RULE2] select lines latched on strobe rising edge, then setup recalled
// [RULE3] measuring output on while testing, not during output ramp
// [RULE4] pass output pulses about 0.2 s on a passing judgement
// [RULE5] pass output held steadily when holding time is indefinite
// [RULE6] upper fail output steady after upper limit failure
// [RULE7] lower fail output steady after lower limit failure
// [RULE8] protection output on while protection state lasts
// [RULE9] pass-hold mode keeps pass state for the holding time
// [RULE10] momentary mode tests only while start is held
// [RULE11] stop lockout ignores remote stop for fail or protection
// [RULE12] two-action start needs start within 0.5 s of stop release
// [RULE13] contact start begins a test when output current flows
// [RULE14] a program runs up to 100 steps in sequence
// [RULE15] up to 100 programs, 500 steps in total
// [RULE16] talker function without talk-only
// [RULE17] listener function without listen-only
// [RULE18] all connector inputs active low
// [RULE19] open input reads as inactive high
// [RULE20] start taken only with permit active; ready only when idle
`timescale 1ns/1ps
`include "rtci_params.svh"
module rtci_top #(
  parameter int unsigned MS_CYCLES = `RTCI_MS_CYCLES
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [7:0]           s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  input  wire logic [7:0]           select_bits_n,
  input  wire logic                 select_strobe_n,
  input  wire logic                 start_n,
  input  wire logic                 stop_n,
  input  wire logic                 start_permit_n,
  input  wire rtci_pkg::rtci_judge_t judge,
  output rtci_pkg::rtci_out_t       pins,
  output logic                      recall,
  output logic [6:0]                prog_num,
  output logic [6:0]                step_idx
);
  typedef struct packed {
    rtci_pkg::rtci_state_t st;
    rtci_pkg::rtci_ctrl_t  ctrl;
    logic                  forever_hold;
    logic [15:0]           hold_ms;
    logic [99:0][6:0]      prog_steps;
    logic [8:0]            total;
    logic [7:0]            code;
    logic [6:0]            num;
    logic [6:0]            steps;
    logic [6:0]            step;
    logic                  recall;
    logic                  ufail;
    logic                  lfail;
    logic [15:0]           tmr;
    logic [7:0]            pulse_ms;
    logic [9:0]            win_ms;
    logic                  strobe_q;
    logic                  start_q;
    logic                  stop_q;
    logic                  talk;
    logic                  listen;
    rtci_pkg::rtci_out_t   out;
    logic                  aw_full;
    logic                  w_full;
    logic [7:0]            aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } rtci_top_t;

  rtci_top_t  r_reg;
  rtci_top_t  r_next;
  logic [11:0] pin_s;
  logic        tick;
  logic        sw_start;
  logic        sw_stop;

  // ----------------------------------------------------------------
  // pin synchronisers and millisecond tick
  // ----------------------------------------------------------------
  rtci_sync #(.W(12)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({start_permit_n, stop_n, start_n, select_strobe_n,
               select_bits_n}),
    .dout    (pin_s)
  ); // see [RULE19]

  rtci_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic bcd_ok(input logic [7:0] c);
    return (c[3:0] <= 4'h9) && (c[7:4] <= 4'h9);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0]  sel;
    logic        start_act;
    logic        stop_act;
    logic        permit;
    logic        start_rise;
    logic        stop_rise;
    logic        start_req;
    logic [31:0] v;
    logic [6:0]  idx;
    logic [6:0]  cnt;
    logic [9:0]  sum;
    sel        = ~pin_s[7:0]; // see [RULE18] [RULE1]
    start_act  = ~pin_s[9];
    stop_act   = ~pin_s[10];
    permit     = ~pin_s[11];
    start_rise = start_act & ~r_reg.start_q;
    stop_rise  = stop_act & ~r_reg.stop_q;
    v          = '0;
    idx        = '0;
    cnt        = '0;
    sum        = '0;
    sw_start   = 1'b0;
    sw_stop    = 1'b0;
    r_next          = r_reg;
    r_next.recall   = 1'b0;
    r_next.strobe_q = pin_s[8];
    r_next.start_q  = start_act;
    r_next.stop_q   = stop_act;

    // write channel
    if (s_axi_awvalid && r_reg.awready)
    begin
      r_next.aw_full = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wready)
    begin
      r_next.w_full = 1'b1;
      r_next.w_data = s_axi_wdata;
      r_next.w_strb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready)
    begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_full && r_reg.w_full && !r_reg.bvalid)
    begin
      r_next.aw_full = 1'b0;
      r_next.w_full  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = `RTCI_RESP_OKAY;
      unique case (r_reg.aw_addr)
        `RTCI_OFF_CTRL:
        begin
          v = merge({27'h0, r_reg.ctrl}, r_reg.w_data, r_reg.w_strb);
          r_next.ctrl = v[4:0];
          sw_start = r_reg.w_strb[0] & r_reg.w_data[`RTCI_SW_START_BIT];
          sw_stop  = r_reg.w_strb[0] & r_reg.w_data[`RTCI_SW_STOP_BIT];
        end
        `RTCI_OFF_HOLD:
        begin
          v = merge({15'h0, r_reg.forever_hold, r_reg.hold_ms},
                    r_reg.w_data, r_reg.w_strb);
          r_next.hold_ms      = v[15:0];
          r_next.forever_hold = v[`RTCI_FOREVER_BIT];
        end
        `RTCI_OFF_PROG:
        begin
          idx = r_reg.w_data[6:0];
          cnt = r_reg.w_data[`RTCI_PROG_CNT_LSB +: 7];
          if (idx < `RTCI_PROGS_MAX)
          begin
            sum = {1'b0, r_reg.total} - {3'h0, r_reg.prog_steps[idx]}
                  + {3'h0, cnt};
          end
          if (idx < `RTCI_PROGS_MAX && cnt <= `RTCI_STEPS_MAX &&
              sum <= `RTCI_TOTAL_MAX) // see [RULE14] [RULE15]
          begin
            r_next.prog_steps[idx] = cnt;
            r_next.total           = sum[8:0];
          end
          else
          begin
            r_next.bresp = `RTCI_RESP_SLVERR;
          end
        end
        `RTCI_OFF_BUSIF:
        begin
          // only-modes are not offered and read as zero
          v = merge({30'h0, r_reg.listen, r_reg.talk}, r_reg.w_data,
                    r_reg.w_strb);
          r_next.talk   = v[0]; // see [RULE16]
          r_next.listen = v[1]; // see [RULE17]
        end
        default: r_next.bresp = `RTCI_RESP_SLVERR;
      endcase
    end
    r_next.awready = !r_next.aw_full;
    r_next.wready  = !r_next.w_full;

    // read channel
    if (r_reg.rvalid && s_axi_rready)
    begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.arready)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = `RTCI_RESP_OKAY;
      unique case (s_axi_araddr)
        `RTCI_OFF_CTRL:   r_next.rdata = {27'h0, r_reg.ctrl};
        `RTCI_OFF_HOLD:   r_next.rdata = {15'h0, r_reg.forever_hold,
                                          r_reg.hold_ms};
        `RTCI_OFF_PROG:   r_next.rdata = {25'h0, r_reg.steps};
        `RTCI_OFF_STATUS: r_next.rdata = {9'h0, r_reg.ufail, r_reg.lfail,
                                          permit, stop_act, start_act,
                                          r_reg.steps, r_reg.step,
                                          r_reg.out.pass, r_reg.st};
        `RTCI_OFF_SELECT: r_next.rdata = {17'h0, r_reg.num, r_reg.code};
        `RTCI_OFF_TOTAL:  r_next.rdata = {23'h0, r_reg.total};
        `RTCI_OFF_BUSIF:  r_next.rdata = {30'h0, r_reg.listen, r_reg.talk};
        default:
        begin
          r_next.rdata = 32'h0;
          r_next.rresp = `RTCI_RESP_SLVERR;
        end
      endcase
    end
    r_next.arready = !r_next.rvalid;

    // select strobe and recall
    if (pin_s[8] && !r_reg.strobe_q && bcd_ok(sel) &&
        r_reg.st != rtci_pkg::RTCI_ST_RAMP &&
        r_reg.st != rtci_pkg::RTCI_ST_MEAS) // see [RULE2]
    begin
      r_next.code   = sel;
      r_next.num    = 7'({3'h0, sel[7:4]} * 7'ha + {3'h0, sel[3:0]});
      r_next.steps  = (r_reg.prog_steps[r_next.num] == 7'h0) ?
                      `RTCI_STEPS_RST : r_reg.prog_steps[r_next.num];
      r_next.recall = 1'b1;
    end

    // timers
    if (stop_act == 1'b0 && r_reg.stop_q)
    begin
      r_next.win_ms = `RTCI_TWO_ACTION_MS;
    end
    else if (tick && r_reg.win_ms != 10'h0)
    begin
      r_next.win_ms = r_reg.win_ms - 10'h1;
    end
    if (tick && r_reg.pulse_ms != 8'h0)
    begin
      r_next.pulse_ms = r_reg.pulse_ms - 8'h1;
    end
    if (tick && r_reg.tmr != 16'h0)
    begin
      r_next.tmr = r_reg.tmr - 16'h1;
    end

    // test sequencer
    start_req = (permit && start_rise &&
                 (!r_reg.ctrl.two_action || r_reg.win_ms != 10'h0)) ||
                sw_start; // see [RULE20] [RULE12]
    unique case (r_reg.st)
      rtci_pkg::RTCI_ST_IDLE:
      begin
        if (start_req || (r_reg.ctrl.contact_start &&
            judge.contact_current)) // see [RULE13]
        begin
          r_next.st   = rtci_pkg::RTCI_ST_RAMP;
          r_next.step = 7'h0;
        end
      end
      rtci_pkg::RTCI_ST_RAMP, rtci_pkg::RTCI_ST_MEAS:
      begin
        if (stop_act || sw_stop ||
            (r_reg.ctrl.momentary && !start_act)) // see [RULE10]
        begin
          r_next.st = rtci_pkg::RTCI_ST_IDLE;
        end
        else if (r_reg.st == rtci_pkg::RTCI_ST_RAMP)
        begin
          if (judge.ramp_done)
          begin
            r_next.st = rtci_pkg::RTCI_ST_MEAS; // see [RULE3]
          end
        end
        else if (judge.upper_fail || judge.lower_fail)
        begin
          r_next.st    = rtci_pkg::RTCI_ST_FAIL;
          r_next.ufail = judge.upper_fail; // see [RULE6]
          r_next.lfail = judge.lower_fail; // see [RULE7]
        end
        else if (judge.pass)
        begin
          r_next.pulse_ms = `RTCI_PASS_PULSE_MS; // see [RULE4]
          if (r_reg.step + 7'h1 < r_reg.steps) // see [RULE14]
          begin
            r_next.step = r_reg.step + 7'h1;
            r_next.st   = rtci_pkg::RTCI_ST_RAMP;
          end
          else
          begin
            r_next.st  = rtci_pkg::RTCI_ST_PASS;
            r_next.tmr = r_reg.hold_ms;
          end
        end
      end
      rtci_pkg::RTCI_ST_PASS:
      begin
        if (start_req)
        begin
          r_next.st   = rtci_pkg::RTCI_ST_RAMP;
          r_next.step = 7'h0;
        end
        else if (stop_act || sw_stop || !r_reg.ctrl.pass_hold ||
                 (!r_reg.forever_hold && r_reg.tmr == 16'h0))
        begin
          r_next.st = rtci_pkg::RTCI_ST_IDLE; // see [RULE9]
        end
      end
      rtci_pkg::RTCI_ST_FAIL, rtci_pkg::RTCI_ST_PROT:
      begin
        if (sw_stop || (stop_rise && !r_reg.ctrl.stop_lockout))
        begin
          r_next.st    = rtci_pkg::RTCI_ST_IDLE; // see [RULE11]
          r_next.ufail = 1'b0;
          r_next.lfail = 1'b0;
        end
      end
      default: r_next.st = rtci_pkg::RTCI_ST_IDLE;
    endcase
    if (judge.protect)
    begin
      r_next.st = rtci_pkg::RTCI_ST_PROT;
    end

    // connector outputs
    r_next.out.test_on    = (r_next.st == rtci_pkg::RTCI_ST_RAMP) ||
                            (r_next.st == rtci_pkg::RTCI_ST_MEAS);
    r_next.out.measuring  = (r_next.st == rtci_pkg::RTCI_ST_MEAS);
    r_next.out.pass       = (r_next.pulse_ms != 8'h0) ||
                            (r_next.st == rtci_pkg::RTCI_ST_PASS &&
                             r_reg.ctrl.pass_hold); // see [RULE5] [RULE9]
    r_next.out.upper_fail = (r_next.st == rtci_pkg::RTCI_ST_FAIL) &&
                            r_next.ufail;
    r_next.out.lower_fail = (r_next.st == rtci_pkg::RTCI_ST_FAIL) &&
                            r_next.lfail;
    r_next.out.ready      = (r_next.st == rtci_pkg::RTCI_ST_IDLE) &&
                            permit; // see [RULE20]
    r_next.out.protection = (r_next.st ==
                             rtci_pkg::RTCI_ST_PROT); // see [RULE8]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_reg          <= '0;
      r_reg.steps    <= `RTCI_STEPS_RST;
      r_reg.strobe_q <= `RTCI_PIN_IDLE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready  = r_reg.wready;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;
  assign pins          = r_reg.out;
  assign recall        = r_reg.recall;
  assign prog_num      = r_reg.num;
  assign step_idx      = r_reg.step;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  meas_after_ramp_a: assert property (@(posedge aclk) // see [RULE3]
    disable iff (!aresetn) $rose(pins.measuring) |-> $past(judge.ramp_done))
    else $error("measuring began without ramp done");
  pass_pulse_len_a: assert property (@(posedge aclk) // see [RULE4]
    disable iff (!aresetn)
    $rose(pins.pass) |-> r_reg.pulse_ms == `RTCI_PASS_PULSE_MS)
    else $error("pass pulse not loaded with 200 ms");
  pass_forever_a: assert property (@(posedge aclk) // see [RULE5]
    disable iff (!aresetn)
    (r_reg.st == rtci_pkg::RTCI_ST_PASS && r_reg.ctrl.pass_hold)
    |-> pins.pass)
    else $error("pass output dropped during hold");
  upper_fail_a: assert property (@(posedge aclk) // see [RULE6]
    disable iff (!aresetn) $rose(pins.upper_fail) |-> $past(judge.upper_fail))
    else $error("upper fail without judgement");
  lower_fail_a: assert property (@(posedge aclk) // see [RULE7]
    disable iff (!aresetn) $rose(pins.lower_fail) |-> $past(judge.lower_fail))
    else $error("lower fail without judgement");
  protect_out_a: assert property (@(posedge aclk) // see [RULE8]
    disable iff (!aresetn) judge.protect |=> pins.protection)
    else $error("protection output missing");
  momentary_end_a: assert property (@(posedge aclk) // see [RULE10]
    disable iff (!aresetn)
    (r_reg.ctrl.momentary && pins.test_on && pin_s[9]) |=> !pins.test_on)
    else $error("momentary test kept running");
  stop_lockout_a: assert property (@(posedge aclk) // see [RULE11]
    disable iff (!aresetn)
    (r_reg.st == rtci_pkg::RTCI_ST_FAIL && r_reg.ctrl.stop_lockout &&
     !sw_stop && !judge.protect) |=> r_reg.st == rtci_pkg::RTCI_ST_FAIL)
    else $error("remote stop cleared locked fail");
  ready_permit_a: assert property (@(posedge aclk) // see [RULE20]
    disable iff (!aresetn)
    pins.ready |-> (r_reg.st == rtci_pkg::RTCI_ST_IDLE && !$past(pin_s[11])))
    else $error("ready without idle and permit");
endmodule

// ### testbench/rtci_box.sv
// operator box model driving the active-low connector inputs
// assumes the bench sets request levels just after a clock edge
`timescale 1ns/1ps
module rtci_box (
  input  wire logic       aclk,
  input  wire logic [7:0] code,
  input  wire logic       strobe,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic       permit,
  output logic      [7:0] select_bits_n,
  output logic            select_strobe_n,
  output logic            start_n,
  output logic            stop_n,
  output logic            start_permit_n
);
  initial
  begin
    {select_bits_n, select_strobe_n, start_n, stop_n, start_permit_n} = '1;
  end
  always @(posedge aclk)
  begin
    select_bits_n   <= ~code;
    select_strobe_n <= ~strobe;
    start_n         <= ~start;
    stop_n          <= ~stop;
    start_permit_n  <= ~permit;
  end
endmodule

// ### testbench/tb_remote_test_control_io.sv
// bench for the remote test control block
// assumes rtci_box at the connector, one ms scaled to 10 cycles
`timescale 1ns/1ps
`include "rtci_params.svh"
module tb_remote_test_control_io;
  logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid;
  logic                  rready, awready, wready, bvalid, arready, rvalid;
  logic                  recall, strobe, start, stop, permit;
  logic                  strb_n, start_n, stop_n, perm_n;
  logic [7:0]            awaddr, araddr, code, sel_n;
  logic [31:0]           wdata, rdata, rv;
  logic [1:0]            bresp, rresp, resp;
  logic [6:0]            prog_num, pv, sidx;
  rtci_pkg::rtci_judge_t judge;
  rtci_pkg::rtci_out_t   pins;
  int                    num_errors, total_checks, n, t, u;
  assign pv = pins;
  rtci_top #(.MS_CYCLES(10)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .select_bits_n(sel_n),
    .select_strobe_n(strb_n), .start_n(start_n), .stop_n(stop_n),
    .start_permit_n(perm_n), .judge(judge), .pins(pins), .recall(recall),
    .prog_num(prog_num), .step_idx(sidx));
  rtci_box box (.aclk(aclk), .code(code), .strobe(strobe), .start(start),
    .stop(stop), .permit(permit), .select_bits_n(sel_n),
    .select_strobe_n(strb_n), .start_n(start_n), .stop_n(stop_n),
    .start_permit_n(perm_n));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic results();
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok)
    begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic pj(input int b);
    judge[b] <= 1'b1;
    @(posedge aclk);
    judge[b] <= 1'b0;
  endtask
  task automatic wp(input int b, input logic v);
    for (n = 0; pv[b] !== v && n < 3000; n++)
      @(posedge aclk);
    if (n == 3000)
    begin
      chk(0, "output wait");
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    bit done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (i = 0; i < 50 && !done; i++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
    begin
      chk(0, "write hang");
      results();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    bit done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (i = 0; i < 50 && !done; i++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        resp = rresp;
        rv = rdata;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
    begin
      chk(0, "read hang");
      results();
    end
  endtask
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, code, strobe, start, stop, permit} = '0;
    judge = '0;
    void'($urandom(41));
    cyc(3);
    aresetn <= 1'b1;
    cyc(3);
    t = $urandom % 10;
    u = $urandom % 10;
    code <= {t[3:0], u[3:0]};
    strobe <= 1'b1;
    cyc(4);
    strobe <= 1'b0;
    for (n = 0; recall !== 1'b1 && n < 20; n++)
      @(posedge aclk);
    chk(n < 20 && prog_num === 7'(t * 10 + u), "select");
    code <= 8'h5b;
    strobe <= 1'b1;
    cyc(4);
    strobe <= 1'b0;
    n = 0;
    repeat (10) @(posedge aclk) n += (recall === 1'b1);
    chk(n == 0, "bad code");
    permit <= 1'b1;
    wr(8'h00, 32'h20);
    wp(0, 1'b1);
    cyc(3);
    chk(pins.measuring === 1'b0, "ramp");
    judge.ramp_done <= 1'b1;
    cyc(3);
    chk(pins.measuring === 1'b1, "meas");
    pj(4);
    wp(2, 1'b1);
    wp(2, 1'b0);
    chk(n > 1990 && n < 2010, "pulse");
    chk(pins.ready === 1'b1, "ready");
    permit <= 1'b0;
    start <= 1'b1;
    cyc(8);
    chk(pv[5:0] === 6'h0, "permit");
    {permit, start} <= 2'h2;
    wr(8'h04, 32'h10000);
    wr(8'h00, 32'h01);
    start <= 1'b1;
    wp(0, 1'b1);
    start <= 1'b0;
    cyc(3);
    pj(4);
    cyc(2500);
    chk(pins.pass === 1'b1, "hold");
    stop <= 1'b1;
    wp(2, 1'b0);
    stop <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h00, k ? 32'h24 : 32'h20);
      cyc(3);
      pj(k ? 3 : 2);
      wp(k ? 3 : 4, 1'b1);
      stop <= 1'b1;
      cyc(8);
      stop <= 1'b0;
      cyc(4);
      chk(pv[k ? 3 : 4] === 1'(k), "stop");
    end
    wr(8'h00, 32'h40);
    wp(3, 1'b0);
    pj(1);
    wp(6, 1'b1);
    wr(8'h00, 32'h40);
    wp(6, 1'b0);
    wr(8'h00, 32'h02);
    start <= 1'b1;
    wp(0, 1'b1);
    cyc(10);
    start <= 1'b0;
    wp(0, 1'b0);
    chk(n < 8, "momentary");
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h00, 32'h08);
      stop <= 1'b1;
      cyc(6);
      stop <= 1'b0;
      cyc(k ? 6000 : 20);
      start <= 1'b1;
      cyc(10);
      chk(pins.test_on === 1'(!k), "two action");
      start <= 1'b0;
      wr(8'h00, 32'h40);
    end
    wr(8'h00, 32'h10);
    pj(0);
    wp(0, 1'b1);
    wr(8'h00, 32'h40);
    wr(8'h08, 32'h6500);
    chk(resp === `RTCI_RESP_SLVERR, "steps");
    wr(8'h08, 32'h0164);
    chk(resp === `RTCI_RESP_SLVERR, "index");
    wr(8'h08, 32'h0305);
    chk(resp === `RTCI_RESP_OKAY, "store");
    rd(8'h14);
    chk(rv === 32'h3, "total");
    code <= 8'h05;
    strobe <= 1'b1;
    cyc(4);
    strobe <= 1'b0;
    cyc(8);
    wr(8'h00, 32'h20);
    cyc(3);
    pj(4);
    cyc(3);
    chk(sidx === 7'h1 && pins.test_on === 1'b1, "step");
    wr(8'h18, 32'h0f);
    rd(8'h18);
    chk(rv === 32'h3, "bus if");
    rd(8'h1c);
    chk(resp === `RTCI_RESP_SLVERR && rv === 32'h0, "unmapped");
    results();
  end
endmodule
